// ### test/spwc_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// Supply and oscillator stand-in
// ----------------------------------------
module spwc_partner (
    // Clock and fault control
    input wire logic i_clk,
    input wire logic i_fail,
    // Oscillator and supply sense
    output logic o_osc,
    output logic o_power_ok
);
    logic [2:0] div = 3'h0;
    // Oscillator runs free, even with main power gone
    always @(posedge i_clk) begin
        div <= div + 3'h1;
    end
    assign o_osc = div[2];
    assign o_power_ok = ~i_fail;
endmodule // spwc_partner

// ### test/tb.sv
`timescale 1ns/1ps
`include "spwc_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
n_mismatch++; $display("wrong value at %0t: mismatch", $time); end end
module tb;
    import spwc_pkg::*;
    logic i_clk = 0, i_reset_n = 0, fail = 0, alarm = 0;
    logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic aw_r, w_r, b_v, ar_r, r_v, osc, pok, sup, irq, irq_oe_n;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    spwc_resp_type b_s, r_s;
    logic pnl = 1, ms = 1, kb = 1, rb = 1, ra = 1, ph = 1, w2 = 1, w1 = 1;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    initial forever #12.5 i_clk = ~i_clk;
    spwc_partner PART (.i_clk(i_clk), .i_fail(fail), .o_osc(osc),
        .o_power_ok(pok));
    spwc_top #(.OSC_PER_SEC(8), .HOLD_TICKS(32), .RING_TICKS(20),
        .RING_GAP(6), .DEB_TICKS(2)) DUT (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_axi_awvalid(aw_v), .o_axi_awready(aw_r),
        .i_axi_awaddr(awa), .i_axi_wvalid(w_v), .o_axi_wready(w_r),
        .i_axi_wdata(wd), .i_axi_wstrb(4'hF), .o_axi_bvalid(b_v),
        .i_axi_bready(b_r), .o_axi_bresp(b_s), .i_axi_arvalid(ar_v),
        .o_axi_arready(ar_r), .i_axi_araddr(ara), .o_axi_rvalid(r_v),
        .i_axi_rready(r_r), .o_axi_rdata(rd), .o_axi_rresp(r_s),
        .i_rtc_osc(osc), .i_panel_switch_n(pnl), .i_mouse_clock_in(ms),
        .i_kbd_clock_in(kb), .i_modem_ring_b(rb), .i_modem_ring_a(ra),
        .i_phone_ring_in(ph), .i_wake_input_two(w2),
        .i_wake_input_one(w1), .i_main_power_ok(pok),
        .i_alarm_b_match(alarm), .o_supply_control_out(sup),
        .o_mgmt_irq_out(irq), .o_mgmt_irq_oe_n(irq_oe_n));
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        awa <= a; wd <= {24'h0, d}; aw_v <= 1; w_v <= 1; b_r <= 1;
        forever begin
            @(posedge i_clk);
            if (aw_r) aw_v <= 0;
            if (w_r) w_v <= 0;
            if (b_v === 1'b1) break;
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
        input spwc_resp_type es);
        ara <= a; ar_v <= 1; r_r <= 1;
        forever begin
            @(posedge i_clk);
            if (ar_r) ar_v <= 0;
            if (r_v === 1'b1) break;
        end
        `CHK(rd, e)
        `CHK(r_s, es)
    endtask
    task automatic t_reset;
        `CHK(sup, 1'b0)
        rchk(12'(`SPWC_ADDR_CTRL), 32'h0, `SPWC_RESP_OKAY);
        rchk(12'(`SPWC_ADDR_STA), 32'h80, `SPWC_RESP_OKAY);
        rchk(12'h000, 32'h0, `SPWC_RESP_SLVERR);
    endtask
    task automatic t_wake;
        wr(12'(`SPWC_ADDR_WAKE), 8'h02);
        w1 <= 0;
        w(10);
        `CHK(sup, 1'b1)
        rchk(12'(`SPWC_ADDR_STB), 32'h01, `SPWC_RESP_OKAY);
        rchk(12'(`SPWC_ADDR_STB), 32'h00, `SPWC_RESP_OKAY);
        w1 <= 1;
    endtask
    task automatic t_soft;
        wr(12'(`SPWC_ADDR_CTRL), 8'h20);
        w(4);
        `CHK(sup, 1'b0)
        rchk(12'(`SPWC_ADDR_CTRL), 32'h0, `SPWC_RESP_OKAY);
    endtask
    task automatic t_fail;
        fail <= 1;
        w(10);
        rchk(12'(`SPWC_ADDR_CTRL), 32'h90, `SPWC_RESP_OKAY);
        w1 <= 0;
        w(10);
        `CHK(sup, 1'b0)
        w1 <= 1;
        fail <= 0;
        wr(12'(`SPWC_ADDR_CTRL), 8'h80);
        rchk(12'(`SPWC_ADDR_CTRL), 32'h0, `SPWC_RESP_OKAY);
    endtask
    task automatic t_panel;
        pnl <= 0;
        w(40);
        `CHK(sup, 1'b1)
        pnl <= 1;
        w(40);
        pnl <= 0;
        w(40);
        `CHK(sup, 1'b0)
        pnl <= 1;
        w(40);
    endtask
    task automatic t_detect;
        wr(12'(`SPWC_ADDR_CTRL), 8'h04);
        wr(12'(`SPWC_ADDR_WAKE), 8'h01);
        {ms, kb, rb, ra, ph, w2} <= 6'h00;
        alarm <= 1;
        w(8);
        `CHK(sup, 1'b1)
        `CHK(irq_oe_n, 1'b0)
        `CHK(irq, 1'b1)
        rchk(12'(`SPWC_ADDR_STA), 32'h2F, `SPWC_RESP_OKAY);
        rchk(12'(`SPWC_ADDR_STB), 32'h0F, `SPWC_RESP_OKAY);
        {ms, kb, rb, ra, ph, w2} <= 6'h3F;
        alarm <= 0;
        wr(12'(`SPWC_ADDR_CTRL), 8'h0C);
        w(6);
        `CHK(irq_oe_n, 1'b1)
        rchk(12'(`SPWC_ADDR_STA), 32'hA0, `SPWC_RESP_OKAY);
        rchk(12'(`SPWC_ADDR_STB), 32'h00, `SPWC_RESP_OKAY);
    endtask
    task automatic t_delay;
        wr(12'(`SPWC_ADDR_STB), 8'h40);
        pnl <= 0;
        w(40);
        pnl <= 1;
        w(260);
        `CHK(sup, 1'b1)
        w(70);
        `CHK(sup, 1'b0)
        rchk(12'(`SPWC_ADDR_STA), 32'hB0, `SPWC_RESP_OKAY);
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Cuts a hang in any bus wait short
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial begin
        w(3);
        i_reset_n <= 1;
        w(8);
        t_reset;
        t_wake;
        t_soft;
        t_fail;
        t_panel;
        t_detect;
        t_delay;
        end_of_test;
    end
endmodule // tb

// ### verilog/spwc_map.svh
`ifndef SPWC_MAP_SVH
`define SPWC_MAP_SVH
// ----------------------------------------
// Register indexes; byte address = 4 * index
// ----------------------------------------
`define SPWC_IDX_CTRL 8'h49
`define SPWC_IDX_WAKE 8'h4A
`define SPWC_IDX_STA 8'h4B
`define SPWC_IDX_STB 8'h4C
`define SPWC_ADDR_CTRL {2'h0, `SPWC_IDX_CTRL, 2'h0}
`define SPWC_ADDR_WAKE {2'h0, `SPWC_IDX_WAKE, 2'h0}
`define SPWC_ADDR_STA {2'h0, `SPWC_IDX_STA, 2'h0}
`define SPWC_ADDR_STB {2'h0, `SPWC_IDX_STB, 2'h0}
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPWC_B_PF 7
`define SPWC_B_CLRSAVE 6
`define SPWC_B_SOFTOFF 5
`define SPWC_B_ACTDIS 4
`define SPWC_B_IRQCLR 3
`define SPWC_B_IRQLVL 2
`define SPWC_B_RINGMODE 1
`define SPWC_B_TMRSTOP 0
`define SPWC_B_RINGLVL 7
`define SPWC_B_PNLOFF 5
`define SPWC_F_SEEN_A 4:0
`define SPWC_B_SELHI 7
`define SPWC_B_SELLO 6
`define SPWC_B_POL 5
`define SPWC_F_SEEN_B 3:0
// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define SPWC_RST_BYTE 8'h00
`define SPWC_RESP_OKAY 2'h0
`define SPWC_RESP_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPWC_OSC_HZ 32768
`define SPWC_HOLD_S 4
`define SPWC_RING_MS 200
`define SPWC_RING_HZ 11
`define SPWC_DEB_TICKS 32
`define SPWC_DLY1_S 5'h05
`define SPWC_DLY2_S 5'h0D
`define SPWC_DLY3_S 5'h15
// ----------------------------------------
// Synchronised pin vector positions
// ----------------------------------------
`define SPWC_P_OSC 0
`define SPWC_P_PANEL 1
`define SPWC_P_MOUSE 2
`define SPWC_P_KBD 3
`define SPWC_P_RB 4
`define SPWC_P_RA 5
`define SPWC_P_PHONE 6
`define SPWC_P_W2 7
`define SPWC_P_W1 8
`define SPWC_P_PWR 9
`define SPWC_NPINS 10
`endif

// ### verilog/spwc_pkg.sv
package spwc_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_ON = 3'h2,
        ST_WAIT = 3'h4
    } spwc_state_type;
    typedef logic [1:0] spwc_resp_type;
endpackage

// ### verilog/spwc_top.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "spwc_map.svh"
module spwc_top #(
    parameter int OSC_PER_SEC = `SPWC_OSC_HZ,
    parameter int HOLD_TICKS = `SPWC_OSC_HZ * `SPWC_HOLD_S,
    parameter int RING_TICKS =
        (`SPWC_OSC_HZ * `SPWC_RING_MS + 999) / 1000,
    parameter int RING_GAP = `SPWC_OSC_HZ / `SPWC_RING_HZ,
    parameter int DEB_TICKS = `SPWC_DEB_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register bus
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [11:0] i_axi_awaddr,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    output spwc_pkg::spwc_resp_type o_axi_bresp,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    input wire logic [11:0] i_axi_araddr,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    output logic [31:0] o_axi_rdata,
    output spwc_pkg::spwc_resp_type o_axi_rresp,
    // Oscillator and wake pins
    input wire logic i_rtc_osc,
    input wire logic i_panel_switch_n,
    input wire logic i_mouse_clock_in,
    input wire logic i_kbd_clock_in,
    input wire logic i_modem_ring_b,
    input wire logic i_modem_ring_a,
    input wire logic i_phone_ring_in,
    input wire logic i_wake_input_two,
    input wire logic i_wake_input_one,
    input wire logic i_main_power_ok,
    input wire logic i_alarm_b_match,
    // Supply and interrupt pins
    output logic o_supply_control_out,
    output logic o_mgmt_irq_out,
    output logic o_mgmt_irq_oe_n
);
    import spwc_pkg::*;
    localparam int CW = $clog2(HOLD_TICKS + 1);
    localparam int NP = `SPWC_NPINS;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [NP-1:0] pin_raw, sy1, sy2, sy3, pin_f, pin_q;
    logic [NP-1:0] fall, rise;
    logic osc_tick;

    assign pin_raw = {i_main_power_ok, i_wake_input_one,
        i_wake_input_two, i_phone_ring_in, i_modem_ring_a,
        i_modem_ring_b, i_kbd_clock_in, i_mouse_clock_in,
        i_panel_switch_n, i_rtc_osc};

    // Level moves only once stages two and three agree
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sy1 <= {NP{1'b1}};
            sy2 <= {NP{1'b1}};
            sy3 <= {NP{1'b1}};
            pin_f <= {NP{1'b1}};
            pin_q <= {NP{1'b1}};
        end else begin
            sy1 <= pin_raw;
            sy2 <= sy1;
            sy3 <= sy2;
            pin_f <= (sy2 & sy3) | (pin_f & (sy2 ^ sy3));
            pin_q <= pin_f;
        end
    end
    assign fall = pin_q & ~pin_f;
    assign rise = ~pin_q & pin_f;
    // All timing runs off oscillator ticks, never off the bus clock
    assign osc_tick = rise[`SPWC_P_OSC];

    // ----------------------------------------
    // Panel switch debounce and override hold
    // ----------------------------------------
    spwc_state_type state, next_state;
    logic [7:0] deb_cnt;
    logic pnl_deb, pnl_press;
    logic [CW-1:0] hold_cnt;
    logic press_on, hold_fired, override;

    // No oscillator, no ticks: switch never qualifies
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            deb_cnt <= 8'h00;
            pnl_deb <= 1'b1;
            pnl_press <= 1'b0;
        end else begin
            pnl_press <= 1'b0;
            if (pin_f[`SPWC_P_PANEL] == pnl_deb) begin
                deb_cnt <= 8'h00;
            end else if (osc_tick) begin
                if (deb_cnt == 8'(DEB_TICKS - 1)) begin
                    pnl_deb <= pin_f[`SPWC_P_PANEL];
                    pnl_press <= ~pin_f[`SPWC_P_PANEL];
                    deb_cnt <= 8'h00;
                end else begin
                    deb_cnt <= deb_cnt + 8'h01;
                end
            end
        end
    end

    // Override only for a press that began with supply on
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_cnt <= '0;
            press_on <= 1'b0;
            hold_fired <= 1'b0;
            override <= 1'b0;
        end else begin
            override <= 1'b0;
            if (pnl_press) begin
                press_on <= (state != ST_OFF);
            end
            if (pnl_deb) begin
                hold_cnt <= '0;
                hold_fired <= 1'b0;
            end else if (osc_tick && press_on && !hold_fired) begin
                if (hold_cnt == CW'(HOLD_TICKS - 1)) begin
                    override <= 1'b1;
                    hold_fired <= 1'b1;
                end else begin
                    hold_cnt <= hold_cnt + CW'(1);
                end
            end
        end
    end

    // ----------------------------------------
    // Phone ring pulse-train detector
    // ----------------------------------------
    logic [CW-1:0] gap, acc;
    logic ring_train, alm_q, alm_evt;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap <= CW'(RING_GAP);
            acc <= '0;
            ring_train <= 1'b0;
        end else begin
            ring_train <= 1'b0;
            if (fall[`SPWC_P_PHONE]) begin
                gap <= '0;
                if (gap < CW'(RING_GAP)) begin
                    if (acc + gap >= CW'(RING_TICKS)) begin
                        ring_train <= 1'b1;
                        acc <= '0;
                    end else begin
                        acc <= acc + gap;
                    end
                end else begin
                    acc <= '0;
                end
            end else if (osc_tick && gap < CW'(RING_GAP)) begin
                gap <= gap + CW'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            alm_q <= 1'b0;
        end else begin
            alm_q <= i_alarm_b_match;
        end
    end
    assign alm_evt = i_alarm_b_match & ~alm_q;

    // ----------------------------------------
    // Register bus decode
    // ----------------------------------------
    logic [11:0] aw_addr;
    logic [7:0] w_data, wd, rd_word;
    logic w_strb0, wr_fire, rd_fire, rd_hit, wr_hit;
    logic wr_c, wr_w, wr_a, wr_b, rd_a, rd_b;
    logic soft_off, clr_save, irq_clr, pf_clr;

    assign wr_fire = ~o_axi_awready & ~o_axi_wready & ~o_axi_bvalid;
    assign wd = w_data & {8{w_strb0}};
    assign wr_c = wr_fire && aw_addr == `SPWC_ADDR_CTRL;
    assign wr_w = wr_fire && aw_addr == `SPWC_ADDR_WAKE;
    assign wr_a = wr_fire && aw_addr == `SPWC_ADDR_STA;
    assign wr_b = wr_fire && aw_addr == `SPWC_ADDR_STB;
    assign wr_hit = wr_c | wr_w | wr_a | wr_b;
    assign rd_fire = i_axi_arvalid & o_axi_arready;
    assign rd_a = rd_fire && i_axi_araddr == `SPWC_ADDR_STA;
    assign rd_b = rd_fire && i_axi_araddr == `SPWC_ADDR_STB;
    // Self-clearing command bits exist only as write pulses
    assign soft_off = wr_c & wd[`SPWC_B_SOFTOFF];
    assign clr_save = wr_c & wd[`SPWC_B_CLRSAVE];
    assign irq_clr = wr_c & wd[`SPWC_B_IRQCLR];
    assign pf_clr = wr_c & wd[`SPWC_B_PF];

    // ----------------------------------------
    // Control and status registers
    // ----------------------------------------
    logic pf, act_dis_bit, act_dis, irq_lvl, ring_mode, tmr_stop;
    logic [7:0] wake_en;
    logic pnl_off, irq_pol, dly_fin;
    logic [1:0] sel;
    logic [4:0] seen_a, set_a;
    logic [3:0] seen_b, set_b;
    logic pf_evt;

    assign pf_evt = fall[`SPWC_P_PWR];
    assign act_dis = act_dis_bit | pf;
    assign set_a = {dly_fin, fall[`SPWC_P_RB], fall[`SPWC_P_RA],
        fall[`SPWC_P_PHONE], alm_evt};
    assign set_b = {fall[`SPWC_P_MOUSE], fall[`SPWC_P_KBD],
        fall[`SPWC_P_W2], fall[`SPWC_P_W1]};

    // A set in the cycle of its clear always wins
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pf <= 1'b0;
        end else if (pf_evt) begin
            pf <= 1'b1;
        end else if (pf_clr) begin
            pf <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            act_dis_bit <= 1'b0;
            irq_lvl <= 1'b0;
            ring_mode <= 1'b0;
            tmr_stop <= 1'b0;
            wake_en <= `SPWC_RST_BYTE;
            sel <= 2'h0;
            irq_pol <= 1'b0;
        end else begin
            if (wr_c) begin
                act_dis_bit <= wd[`SPWC_B_ACTDIS];
                irq_lvl <= wd[`SPWC_B_IRQLVL];
                ring_mode <= wd[`SPWC_B_RINGMODE];
                tmr_stop <= wd[`SPWC_B_TMRSTOP];
            end
            if (wr_w) begin
                wake_en <= wd;
            end
            if (wr_b) begin
                sel <= {wd[`SPWC_B_SELHI], wd[`SPWC_B_SELLO]};
                irq_pol <= wd[`SPWC_B_POL];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen_a <= 5'h00;
            seen_b <= 4'h0;
            pnl_off <= 1'b0;
        end else begin
            seen_a <= set_a | (seen_a & ~{5{rd_a}});
            seen_b <= set_b | (seen_b & ~{4{rd_b}});
            if (pnl_press && state != ST_OFF) begin
                pnl_off <= 1'b1;
            end else if (wr_a) begin
                pnl_off <= wd[`SPWC_B_PNLOFF];
            end
        end
    end

    // ----------------------------------------
    // Supply sequencer
    // ----------------------------------------
    logic wake_act, phone_evt, pwr_back, was_on, kill, dly_done;
    logic [4:0] dly_cnt;
    logic [CW-1:0] presc;

    function automatic logic [4:0] dly_secs(input logic [1:0] s);
        case (s)
            2'h1: dly_secs = `SPWC_DLY1_S;
            2'h2: dly_secs = `SPWC_DLY2_S;
            2'h3: dly_secs = `SPWC_DLY3_S;
            default: dly_secs = 5'h00;
        endcase
    endfunction

    assign phone_evt = ring_mode ? fall[`SPWC_P_PHONE]
                                 : ring_train;
    assign wake_act = |({fall[`SPWC_P_MOUSE], fall[`SPWC_P_KBD],
        fall[`SPWC_P_RB], fall[`SPWC_P_RA], phone_evt, fall[`SPWC_P_W2],
        fall[`SPWC_P_W1], alm_evt} & wake_en);
    assign pwr_back = rise[`SPWC_P_PWR];
    assign kill = pf_evt | soft_off | override;
    assign dly_done = (state == ST_WAIT) && dly_cnt == 5'h00;
    assign dly_fin = dly_done & ~kill;

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (pnl_press || (pwr_back && pf && was_on)) begin
                    next_state = ST_ON;
                end else if (wake_act && !act_dis) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (kill) begin
                    next_state = ST_OFF;
                end else if (pnl_press) begin
                    next_state = (tmr_stop || sel == 2'h0) ? ST_OFF
                                                           : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (kill || dly_done) begin
                    next_state = ST_OFF;
                end else if (clr_save) begin
                    next_state = ST_ON;
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_OFF;
            o_supply_control_out <= 1'b0;
            was_on <= 1'b0;
        end else begin
            state <= next_state;
            o_supply_control_out <= (next_state != ST_OFF);
            if (pf_evt) begin
                was_on <= (state != ST_OFF);
            end else if (state == ST_OFF && next_state == ST_ON) begin
                was_on <= 1'b0;
            end
        end
    end

    // Seconds prescaler restarts with each off request that enters ST_WAIT
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dly_cnt <= 5'h00;
            presc <= '0;
        end else if (state == ST_ON && next_state == ST_WAIT) begin
            dly_cnt <= dly_secs(sel);
            presc <= '0;
        end else if (clr_save) begin
            dly_cnt <= 5'h00;
            presc <= '0;
        end else if (state == ST_WAIT && !tmr_stop && osc_tick
                     && dly_cnt != 5'h00) begin
            if (presc == CW'(OSC_PER_SEC - 1)) begin
                presc <= '0;
                dly_cnt <= dly_cnt - 5'h01;
            end else begin
                presc <= presc + CW'(1);
            end
        end
    end

    // ----------------------------------------
    // Management interrupt pin
    // ----------------------------------------
    logic irq_src, irq_act, next_irq;

    assign irq_src = (|set_a) | (|set_b) | (pnl_press & state != ST_OFF);
    always_comb begin
        if (irq_lvl) begin
            next_irq = irq_src | (irq_act & ~irq_clr);
        end else begin
            next_irq = irq_src;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_act <= 1'b0;
            o_mgmt_irq_oe_n <= 1'b1;
            o_mgmt_irq_out <= 1'b1;
        end else begin
            irq_act <= next_irq;
            o_mgmt_irq_oe_n <= ~next_irq;
            o_mgmt_irq_out <= ~irq_pol;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    always_comb begin
        rd_word = `SPWC_RST_BYTE;
        rd_hit = 1'b1;
        case (i_axi_araddr)
            `SPWC_ADDR_CTRL: begin
                rd_word[`SPWC_B_PF] = pf;
                rd_word[`SPWC_B_ACTDIS] = act_dis;
                rd_word[`SPWC_B_IRQLVL] = irq_lvl;
                rd_word[`SPWC_B_RINGMODE] = ring_mode;
                rd_word[`SPWC_B_TMRSTOP] = tmr_stop;
            end
            `SPWC_ADDR_WAKE: rd_word = wake_en;
            `SPWC_ADDR_STA: begin
                rd_word[`SPWC_B_RINGLVL] = pin_f[`SPWC_P_PHONE];
                rd_word[`SPWC_B_PNLOFF] = pnl_off;
                rd_word[`SPWC_F_SEEN_A] = seen_a;
            end
            `SPWC_ADDR_STB: begin
                rd_word[`SPWC_B_SELHI] = sel[1];
                rd_word[`SPWC_B_SELLO] = sel[0];
                rd_word[`SPWC_B_POL] = irq_pol;
                rd_word[`SPWC_F_SEEN_B] = seen_b;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_axi_awready <= 1'b1;
            o_axi_wready <= 1'b1;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp <= `SPWC_RESP_OKAY;
            aw_addr <= 12'h000;
            w_data <= 8'h00;
            w_strb0 <= 1'b0;
        end else begin
            if (i_axi_awvalid && o_axi_awready) begin
                o_axi_awready <= 1'b0;
                aw_addr <= i_axi_awaddr;
            end else if (wr_fire) begin
                o_axi_awready <= 1'b1;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                o_axi_wready <= 1'b0;
                w_data <= i_axi_wdata[7:0];
                w_strb0 <= i_axi_wstrb[0];
            end else if (wr_fire) begin
                o_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                o_axi_bvalid <= 1'b1;
                o_axi_bresp <= wr_hit ? `SPWC_RESP_OKAY
                                      : `SPWC_RESP_SLVERR;
            end else if (i_axi_bready) begin
                o_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_axi_arready <= 1'b1;
            o_axi_rvalid <= 1'b0;
            o_axi_rdata <= 32'h0000_0000;
            o_axi_rresp <= `SPWC_RESP_OKAY;
        end else if (rd_fire) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid <= 1'b1;
            o_axi_rdata <= {24'h000000, rd_word};
            o_axi_rresp <= rd_hit ? `SPWC_RESP_OKAY
                                  : `SPWC_RESP_SLVERR;
        end else if (o_axi_rvalid && i_axi_rready) begin
            o_axi_rvalid <= 1'b0;
            o_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_soft_off_cut: assert property (soft_off |=> ##0
        !o_supply_control_out) else $error("soft off ignored");
    a_fail_flag_set: assert property (pf_evt |=> pf[*2])
        else $error("failure flag lost");
    a_override_cut: assert property (override |=>
        !o_supply_control_out) else $error("override ignored");
    a_wake_blocked: assert property (state == ST_OFF && act_dis
        && !pnl_press && !pwr_back |=> !o_supply_control_out)
        else $error("wake while disabled");
    a_wake_taken: assert property (state == ST_OFF && wake_act
        && !act_dis && !pf_evt |=> o_supply_control_out)
        else $error("wake lost");
    a_delay_holds: assert property (state == ST_ON && pnl_press
        && !kill && !tmr_stop && sel != 2'h0 |=>
        o_supply_control_out[*2]) else $error("no delay");
    a_irq_level_hold: assert property (irq_lvl && irq_act
        && !irq_clr |=> !o_mgmt_irq_oe_n)
        else $error("level irq dropped");
    a_irq_clear_drop: assert property (irq_clr && !irq_src |=>
        o_mgmt_irq_oe_n) else $error("irq not cleared");
    a_ring_level_read: assert property (rd_a |=>
        o_axi_rdata[`SPWC_B_RINGLVL] == $past(pin_f[`SPWC_P_PHONE]))
        else $error("ring level wrong");
    a_read_clears: assert property (rd_a && !set_a[3] |=>
        !seen_a[3]) else $error("detect not cleared");

    c_wake_on: cover property (state == ST_OFF ##1 state == ST_ON);
    c_delayed_off: cover property (state == ST_WAIT ##1
        state == ST_OFF);
    c_override: cover property (override);
    c_restore: cover property (pwr_back && pf && was_on);

endmodule // spwc_top

// ### verilog/spwc_top_fix.sv
`timescale 1ns/1ps
